// ===== psr_params.svh
// constants of the peripheral soft reset block: register indices, field positions,
// reset values and write masks; included by the package and by the top module
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define PSR_DUR_IDX 16'h1c04
`define PSR_TRIG_IDX 16'h1c05

// ==========================================================
// reset values
`define PSR_DUR_RST 16'h0000
`define PSR_TRIG_RST 8'h00

// ==========================================================
// trigger register field positions
`define PSR_BIT_GROUP_FOUR 7
`define PSR_BIT_RSVD 6
`define PSR_BIT_GROUP_THREE 5
`define PSR_BIT_DMA 4
`define PSR_BIT_USB 3
`define PSR_BIT_ANALOG 2
`define PSR_BIT_GROUP_ONE 1
`define PSR_BIT_I2C 0
`define PSR_TRIG_MASK 8'hbf

// ==========================================================
// least duration that software is expected to program
`define PSR_DUR_MIN 16'h0008

`endif

// ===== psr_periph_model.sv
// partner model: peripheral groups behind the soft resets, measuring each hold
// assumes psr_pkg is compiled first and all groups share pclk
`timescale 1ns/1ps
module psr_periph_model
    import psr_pkg::*;
(
    input wire logic pclk,
    input wire psr_resets_t periph_rst_n,
    output logic [6:0][15:0] last_len
);
    // ==========================================================
    // hold length per group, one bit per shared reset
    logic [6:0] rst_vec;
    logic [6:0][15:0] run = '0;
    assign rst_vec = periph_rst_n;
    // peripherals stay idle while held, so only the length is kept
    always @(posedge pclk) begin
        for (int i = 0; i < 7; i++) begin
            if (!rst_vec[i]) begin
                run[i] <= run[i] + 16'h0001;
            end else begin
                if (run[i] != 16'h0000) last_len[i] <= run[i];
                run[i] <= 16'h0000;
            end
        end
    end
endmodule

// ===== psr_pkg.sv
// types shared by the peripheral soft reset block
// assumes psr_params.svh is on the include path
`include "psr_params.svh"

package psr_pkg;

    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {
        PSR_ST_IDLE = 2'b01,
        PSR_ST_HOLD = 2'b10
    } psr_state_t;

    // ==========================================================
    // active-low resets to the peripheral groups
    typedef struct packed {
        logic group_four;
        logic group_three;
        logic dma;
        logic usb;
        logic analog;
        logic group_one;
        logic i2c;
    } psr_resets_t;

endpackage

// ===== psr_soft_reset.sv
// peripheral soft reset generator with an apb register slave
// assumes one 100 mhz clock pclk, async active-low presetn, and a 16-bit byte address bus
`timescale 1ns/1ps
`include "psr_params.svh"

module psr_soft_reset
    import psr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output psr_resets_t periph_rst_n
);

    // ==========================================================
    // helpers
    function automatic logic [15:0] psr_word_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    function automatic psr_resets_t psr_to_resets_n(input logic [7:0] act);
        psr_resets_t r;
        r.group_four = ~act[`PSR_BIT_GROUP_FOUR];
        r.group_three = ~act[`PSR_BIT_GROUP_THREE];
        r.dma = ~act[`PSR_BIT_DMA];
        r.usb = ~act[`PSR_BIT_USB];
        r.analog = ~act[`PSR_BIT_ANALOG];
        r.group_one = ~act[`PSR_BIT_GROUP_ONE];
        r.i2c = ~act[`PSR_BIT_I2C];
        return r;
    endfunction

    // ==========================================================
    // apb slave: one wait state so every answer leaves a flop
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [15:0] dur_reg, dur_next;
    logic [7:0] active_reg, active_next;
    logic [15:0] count_reg, count_next;
    psr_state_t state_reg, state_next;
    psr_resets_t rst_n_reg, rst_n_next;

    logic hit_dur, hit_trig, wr_acc, trig;
    logic [7:0] trig_bits;

    assign hit_dur = (paddr == psr_word_addr(`PSR_DUR_IDX));
    assign hit_trig = (paddr == psr_word_addr(`PSR_TRIG_IDX));
    assign wr_acc = psel & penable & pready_reg & pwrite;
    // reserved and unimplemented positions never start anything
    assign trig_bits = pwdata[7:0] & `PSR_TRIG_MASK;
    assign trig = wr_acc & hit_trig & (|trig_bits);

    always_comb begin
        pready_next = psel & penable & ~pready_reg;
        pslverr_next = psel & penable & ~pready_reg & ~hit_dur & ~hit_trig;
        prdata_next = prdata_reg;
        if (psel & penable & ~pready_reg & ~pwrite) begin
            if (hit_dur) begin
                prdata_next = {16'h0000, dur_reg};
            end else if (hit_trig) begin
                prdata_next = {24'h000000, active_reg};
            end else begin
                prdata_next = 32'h00000000;
            end
        end
        dur_next = dur_reg;
        if (wr_acc & hit_dur) begin
            dur_next = pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            dur_reg <= `PSR_DUR_RST;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            dur_reg <= dur_next;
        end
    end

    // ==========================================================
    // reset sequencer
    always_comb begin
        state_next = state_reg;
        active_next = active_reg;
        count_next = count_reg;
        case (state_reg)
            PSR_ST_IDLE: begin
                count_next = count_reg;
            end
            PSR_ST_HOLD: begin
                // a zero duration still holds one clock
                if (count_reg <= 16'h0001) begin
                    active_next = `PSR_TRIG_RST;
                    count_next = 16'h0000;
                    state_next = PSR_ST_IDLE;
                end else begin
                    count_next = count_reg - 16'h0001;
                end
            end
            default: begin
                state_next = PSR_ST_IDLE;
                active_next = `PSR_TRIG_RST;
                count_next = 16'h0000;
            end
        endcase
        // set wins over the clear; a retrigger restarts the count for all held groups
        if (trig) begin
            active_next = active_reg | trig_bits;
            count_next = dur_reg;
            state_next = PSR_ST_HOLD;
        end
        rst_n_next = psr_to_resets_n(active_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PSR_ST_IDLE;
            active_reg <= `PSR_TRIG_RST;
            count_reg <= 16'h0000;
            rst_n_reg <= '1;
        end else begin
            state_reg <= state_next;
            active_reg <= active_next;
            count_reg <= count_next;
            rst_n_reg <= rst_n_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign periph_rst_n = rst_n_reg;

    // ==========================================================
    // checks
    logic [16:0] run_reg;
    logic [16:0] len_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 17'h00000;
            len_reg <= 17'h00001;
        end else begin
            if (trig) begin
                run_reg <= 17'h00001;
                len_reg <= (dur_reg == 16'h0000) ? 17'h00001 : {1'b0, dur_reg};
            end else if (active_next != 8'h00) begin
                run_reg <= run_reg + 17'h00001;
            end else begin
                run_reg <= 17'h00000;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hold_len;
        (active_reg != 8'h00 && active_next == 8'h00) |-> run_reg == len_reg;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset held wrong length");

    property p_release;
        (state_reg == PSR_ST_HOLD && count_reg == 16'h0001 && !trig)
            |=> (active_reg == 8'h00 && periph_rst_n == '1);
    endproperty
    a_release: assert property (p_release) else $error("reset not released at zero");

    property p_start;
        trig |=> ((active_reg & $past(trig_bits)) == $past(trig_bits))
            && state_reg == PSR_ST_HOLD;
    endproperty
    a_start: assert property (p_start) else $error("trigger did not start reset");

    property p_zero_write;
        (wr_acc && hit_trig && !trig && state_reg == PSR_ST_HOLD && count_reg > 16'h0001)
            |=> active_reg == $past(active_reg);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed reset");

    property p_read_live;
        (psel && penable && !pready_reg && !pwrite && hit_trig)
            |=> pready_reg && prdata_reg == {24'h000000, $past(active_reg)};
    endproperty
    a_read_live: assert property (p_read_live) else $error("read did not show live reset");

    property p_reserved;
        !active_reg[`PSR_BIT_RSVD] && !(pready_reg && !pwrite && hit_trig && prdata_reg[31:8] != 0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved trigger bits not zero");

    property p_map;
        periph_rst_n == psr_to_resets_n(active_reg);
    endproperty
    a_map: assert property (p_map) else $error("reset output map wrong");

    property p_group_four;
        $rose(active_reg[`PSR_BIT_GROUP_FOUR]) |-> !periph_rst_n.group_four;
    endproperty
    a_group_four: assert property (p_group_four) else $error("group four not reset");

    property p_groups_one_three;
        (active_reg[`PSR_BIT_GROUP_THREE] == !periph_rst_n.group_three)
            && (active_reg[`PSR_BIT_GROUP_ONE] == !periph_rst_n.group_one);
    endproperty
    a_groups_one_three: assert property (p_groups_one_three) else $error("group one or three wrong");

    property p_count_free;
        (state_reg == PSR_ST_HOLD && count_reg > 16'h0001 && !trig)
            |=> count_reg == $past(count_reg) - 16'h0001;
    endproperty
    a_count_free: assert property (p_count_free) else $error("counter disturbed");

    c_min_trigger: cover property (trig && dur_reg == `PSR_DUR_MIN);
    c_retrigger: cover property (trig && state_reg == PSR_ST_HOLD);
    c_poll_active: cover property (pready_reg && !pwrite && hit_trig && prdata_reg[7:0] != 0);
    c_unmapped: cover property (pready_reg && pslverr_reg);

endmodule

// ===== testbench.sv
// testbench of the peripheral soft reset block: apb master, random durations
// assumes psr_pkg, psr_params.svh and psr_periph_model are compiled first
`timescale 1ns/1ps
`include "psr_params.svh"
module testbench;
    import psr_pkg::*;
    localparam logic [15:0] DUR_ADDR = 16'(`PSR_DUR_IDX * 4);
    localparam logic [15:0] TRIG_ADDR = 16'(`PSR_TRIG_IDX * 4);
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    psr_resets_t periph_rst_n;
    logic [6:0][15:0] last_len;
    logic [15:0] rnd = 16'h0051;
    logic [31:0] rdat;
    logic [15:0] dur;
    logic [7:0] trig;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    always #5 pclk = ~pclk;
    psr_soft_reset i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_rst_n(periph_rst_n));
    psr_periph_model i_periph(.pclk(pclk), .periph_rst_n(periph_rst_n), .last_len(last_len));
    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [31:0] exp_rst(input logic [7:0] t);
        return {25'h0, ~{t[7], t[5:0]}};
    endfunction
    task automatic finish_test();
        if (fail_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // one idle cycle before each setup keeps every signal to one change per step
    // waits as long as the slave needs; only the cycle ceiling ends a hung transfer
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        chk({31'h0, pslverr}, {31'h0, err}, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_release(input int i, input logic [15:0] len);
        int n;
        n = 0;
        do begin
            apb(1'b0, TRIG_ADDR, 32'h0, 1'b0);
            n++;
        end while (rdat !== 32'h0 && n < 40);
        chk(rdat, 32'h0, "bits clear");
        chk({16'h0, last_len[i]}, {16'h0, len}, "hold length");
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DUR_ADDR, 32'h0, 1'b0);
        chk(rdat, 32'h0, "duration reset");
        apb(1'b0, TRIG_ADDR, 32'h0, 1'b0);
        chk(rdat, 32'h0, "trigger reset");
        apb(1'b1, TRIG_ADDR + 16'h0004, 32'hffff_ffff, 1'b1);
        apb(1'b0, TRIG_ADDR + 16'h0004, 32'h0, 1'b1);
        chk(rdat, 32'h0, "unmapped read");
        for (int b = 7; b >= 0; b--) begin
            rnd = lfsr(rnd);
            dur = 16'h0010 + {12'h0, rnd[3:0]};
            trig = 8'(1 << b);
            apb(1'b1, DUR_ADDR, {rnd, dur}, 1'b0);
            apb(1'b0, DUR_ADDR, 32'h0, 1'b0);
            chk(rdat, {16'h0, dur}, "duration readback");
            apb(1'b1, TRIG_ADDR, {rnd, rnd[7:0], trig}, 1'b0);
            #1;
            chk({25'h0, periph_rst_n}, exp_rst(trig), "resets low");
            apb(1'b1, DUR_ADDR, 32'h0000_0003, 1'b0);
            apb(1'b1, TRIG_ADDR, {rnd, rnd[7:0], 8'h40}, 1'b0);
            apb(1'b0, TRIG_ADDR, 32'h0, 1'b0);
            chk(rdat, {24'h0, trig & `PSR_TRIG_MASK}, "live state");
            #1;
            chk({25'h0, periph_rst_n}, exp_rst(trig), "still held");
            if (b != 6) wait_release((b == 7) ? 6 : b, dur);
        end
        rnd = lfsr(rnd);
        trig = rnd[7:0] | 8'h01;
        apb(1'b1, DUR_ADDR, {16'h0, `PSR_DUR_MIN}, 1'b0);
        apb(1'b1, TRIG_ADDR, {24'h0, trig}, 1'b0);
        #1;
        chk({25'h0, periph_rst_n}, exp_rst(trig), "group resets");
        wait_release(0, `PSR_DUR_MIN);
        // second trigger lands on the last edge of the first hold: set must win,
        // and both groups then share the restarted count of 12
        apb(1'b1, TRIG_ADDR, {24'h0, 8'h01}, 1'b0);
        apb(1'b1, DUR_ADDR, 32'h0000_000c, 1'b0);
        apb(1'b1, TRIG_ADDR, {24'h0, 8'h02}, 1'b0);
        #1;
        chk({25'h0, periph_rst_n}, exp_rst(8'h03), "retrigger held");
        wait_release(1, 16'h000c);
        chk({16'h0, last_len[0]}, 32'h0000_0014, "retrigger length");
        apb(1'b1, DUR_ADDR, {16'h0, `PSR_DUR_MIN}, 1'b0);
        apb(1'b1, TRIG_ADDR, 32'h0000_00bf, 1'b0);
        #1;
        chk({25'h0, periph_rst_n}, exp_rst(8'hbf), "all groups held");
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk({25'h0, periph_rst_n}, exp_rst(8'h00), "reset mid hold");
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DUR_ADDR, 32'h0, 1'b0);
        chk(rdat, 32'h0, "duration after reset");
        apb(1'b0, TRIG_ADDR, 32'h0, 1'b0);
        chk(rdat, 32'h0, "trigger after reset");
        finish_test();
    end
endmodule
